// File: hdl/mit_regs.svh
`ifndef MIT_REGS_SVH
`define MIT_REGS_SVH
// Register offsets (byte addresses, one word each)
`define MIT_OFF_CMD 8'h00
`define MIT_OFF_ACC 8'h04
`define MIT_OFF_STATUS 8'h08
`define MIT_OFF_TBL_PTR_HI 8'h0c
`define MIT_OFF_TBL_DATA_HI 8'h10
`define MIT_OFF_T0_MODE 8'h14
`define MIT_OFF_ROM_ADDR 8'h18
`define MIT_OFF_ROM_DATA 8'h1c
`define MIT_OFF_SPR_BASE 8'h40
// Command word fields
`define MIT_CMD_OP_LSB 8
`define MIT_CMD_IMM_LSB 0
// Status bit positions
`define MIT_ST_C 0
`define MIT_ST_DC 1
`define MIT_ST_Z 2
`define MIT_ST_BUSY 3
// Reset values
`define MIT_RST_BYTE 8'h00
// Number of special-page registers
`define MIT_SPR_COUNT 15
// Cycles taken by the table read
`define MIT_TBL_CYCLES 2
`endif

// File: hdl/mit_pkg.sv
`default_nettype none
package mit_pkg;
	typedef enum logic [1:0] {
		MIT_OP_SUB_IMM,
		MIT_OP_TBL_READ,
		MIT_OP_SPR_WRITE,
		MIT_OP_T0_WRITE
	} mit_op_e;
	typedef struct packed {
		logic zero;
		logic half_carry;
		logic carry;
	} mit_flags_s;
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} mit_bus_req_s;
endpackage
`default_nettype wire

// File: hdl/mit_core.sv
`include "mit_regs.svh"
`default_nettype none
module mit_core #(
	parameter int ROM_WORDS = 2048
) (
	input wire logic clk_sys_in, // System clock, 100 MHz
	input wire logic arst_n_in, // Asynchronous reset, active low
	input wire logic [7:0] avs_address_in, // Byte address
	input wire logic avs_read_in, // Read strobe
	input wire logic avs_write_in, // Write strobe
	input wire logic [31:0] avs_writedata_in, // Write data
	output logic [31:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Stall, low when accepted
	output logic [7:0] timer_zero_mode_out, // Timer-zero mode value
	output logic [7:0] acc_out // Accumulator value
);
	import mit_pkg::*;

	logic rst_meta_n;
	logic rst_n;
	mit_bus_req_s req;
	logic [7:0] acc;
	mit_flags_s flags;
	logic [2:0] table_pointer_high;
	logic [5:0] table_data_high;
	logic [7:0] timer_zero_mode_reg;
	logic [7:0] special_page_register [`MIT_SPR_COUNT];
	logic [13:0] rom [ROM_WORDS];
	logic [10:0] rom_load_addr;
	logic tbl_busy;
	logic [10:0] tbl_addr;
	logic [13:0] rom_q;
	logic ack;
	logic next_ack;
	logic cmd_go;
	mit_op_e cmd_op;
	logic [7:0] cmd_imm;
	logic [8:0] diff;
	logic [4:0] diff_lo;

	// Reset release synchroniser; assertion stays asynchronous
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// Decode of a special-page offset, used by the read data mux only
	function automatic logic spr_hit(input logic [7:0] a);
		spr_hit = (a >= `MIT_OFF_SPR_BASE) &&
			(a < (`MIT_OFF_SPR_BASE + 8'(4 * `MIT_SPR_COUNT))) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [3:0] spr_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - `MIT_OFF_SPR_BASE;
		spr_idx = d[5:2];
	endfunction

	assign req = '{address: avs_address_in, read: avs_read_in,
		write: avs_write_in, writedata: avs_writedata_in};
	assign cmd_go = req.write && ack && (req.address == `MIT_OFF_CMD);
	assign cmd_op = mit_op_e'(req.writedata[`MIT_CMD_OP_LSB +: 2]);
	assign cmd_imm = req.writedata[`MIT_CMD_IMM_LSB +: 8];
	// Ninth bit of the difference is the borrow out
	assign diff = {1'b0, cmd_imm} - {1'b0, acc};
	assign diff_lo = {1'b0, cmd_imm[3:0]} - {1'b0, acc[3:0]};

	// Accept one access per idle cycle; a table read stalls the bus until it completes
	assign next_ack = (req.read || req.write) && !ack && !tbl_busy &&
		!(cmd_go && cmd_op == MIT_OP_TBL_READ);
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= next_ack;
		end
	end

	// Waitrequest has its own flop so the port is not an inverter behind ack
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= !next_ack;
		end
	end

	// Table read sequencer: cycle one fetches the word, cycle two loads it
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			tbl_busy <= 1'b0;
			tbl_addr <= '0;
		end else if (cmd_go && cmd_op == MIT_OP_TBL_READ) begin
			tbl_busy <= 1'b1;
			tbl_addr <= {table_pointer_high, acc};
		end else begin
			tbl_busy <= 1'b0;
		end
	end

	// Program ROM with a loader port; has no reset, contents come from software
	always_ff @(posedge clk_sys_in) begin
		if (req.write && ack && req.address == `MIT_OFF_ROM_DATA) begin
			rom[rom_load_addr] <= req.writedata[13:0];
		end
		// Fetch cycle: the word at pointer over accumulator is held for the load cycle
		rom_q <= rom[{table_pointer_high, acc}];
	end

	// Accumulator and flags; the bus may also load the accumulator directly
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			acc <= `MIT_RST_BYTE;
			flags <= '0;
		end else if (tbl_busy) begin
			// low byte to accumulator, flags left alone
			acc <= rom_q[7:0];
		end else if (cmd_go && cmd_op == MIT_OP_SUB_IMM) begin
			acc <= diff[7:0];
			flags.zero <= (diff[7:0] == 8'h00);
			flags.half_carry <= !diff_lo[4];
			// carry is the inverse of borrow
			flags.carry <= !diff[8];
		end else if (req.write && ack && req.address == `MIT_OFF_ACC) begin
			acc <= req.writedata[7:0];
		end
	end

	// Table pointer, table data high and ROM loader address
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			table_pointer_high <= '0;
			table_data_high <= '0;
			rom_load_addr <= '0;
		end else begin
			if (req.write && ack && req.address == `MIT_OFF_TBL_PTR_HI) begin
				table_pointer_high <= req.writedata[2:0];
			end
			if (req.write && ack && req.address == `MIT_OFF_ROM_ADDR) begin
				rom_load_addr <= req.writedata[10:0];
			end else if (req.write && ack && req.address == `MIT_OFF_ROM_DATA) begin
				// Auto-increment makes bulk loading a plain stream of writes
				rom_load_addr <= rom_load_addr + 11'h001;
			end
			if (tbl_busy) begin
				// high six bits to table data high
				table_data_high <= rom_q[13:8];
			end
		end
	end

	// Timer-zero mode register
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			timer_zero_mode_reg <= `MIT_RST_BYTE;
		end else if (cmd_go && cmd_op == MIT_OP_T0_WRITE) begin
			timer_zero_mode_reg <= acc;
		end
	end

	// Special-page registers; index above 14 is dropped
	genvar gi;
	generate
		for (gi = 0; gi < `MIT_SPR_COUNT; gi++) begin : g_spr
			always_ff @(posedge clk_sys_in or negedge rst_n) begin
				if (!rst_n) begin
					special_page_register[gi] <= `MIT_RST_BYTE;
				end else if (cmd_go && cmd_op == MIT_OP_SPR_WRITE &&
					cmd_imm[3:0] == 4'(gi)) begin
					special_page_register[gi] <= acc;
				end
			end
		end
	endgenerate

	// Read data mux, registered on the accepting edge; unmapped reads return zero
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_out <= '0;
		end else if (req.read && !ack && !tbl_busy) begin
			unique case (req.address)
				`MIT_OFF_ACC: avs_readdata_out <= {24'h000000, acc};
				`MIT_OFF_STATUS: avs_readdata_out <= {28'h0000000, tbl_busy,
					flags.zero, flags.half_carry, flags.carry};
				`MIT_OFF_TBL_PTR_HI: avs_readdata_out <= {29'h00000000, table_pointer_high};
				`MIT_OFF_TBL_DATA_HI: avs_readdata_out <= {26'h0000000, table_data_high};
				`MIT_OFF_T0_MODE: avs_readdata_out <= {24'h000000, timer_zero_mode_reg};
				`MIT_OFF_ROM_ADDR: avs_readdata_out <= {21'h000000, rom_load_addr};
				default: begin
					if (spr_hit(req.address)) begin
						avs_readdata_out <= {24'h000000,
							special_page_register[spr_idx(req.address)]};
					end else begin
						avs_readdata_out <= '0;
					end
				end
			endcase
		end
	end

	// Outputs from flops
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			timer_zero_mode_out <= `MIT_RST_BYTE;
			acc_out <= `MIT_RST_BYTE;
		end else begin
			timer_zero_mode_out <= timer_zero_mode_reg;
			acc_out <= acc;
		end
	end

	// Table read starts when the command write is accepted
	sequence s_tbl_start;
		cmd_go && cmd_op == MIT_OP_TBL_READ;
	endsequence
	// Fetch cycle, then load cycle, then idle again
	sequence s_tbl_load;
		##1 tbl_busy ##1 !tbl_busy;
	endsequence
	// A bus request that the slave is free to take on this edge
	sequence s_bus_req;
		(req.read || req.write) && !ack && !tbl_busy;
	endsequence

	a_sub_result: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		cmd_go && cmd_op == MIT_OP_SUB_IMM && !tbl_busy |=> acc == $past(cmd_imm) - $past(acc))
		else $error("subtract result wrong");
	a_sub_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		cmd_go && cmd_op == MIT_OP_SUB_IMM && !tbl_busy |=> flags.zero == (acc == 8'h00))
		else $error("zero flag wrong");
	a_sub_half_carry: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		cmd_go && cmd_op == MIT_OP_SUB_IMM && !tbl_busy |=>
		flags.half_carry == ($past(cmd_imm[3:0]) >= $past(acc[3:0])))
		else $error("half carry flag wrong");
	a_sub_carry: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		cmd_go && cmd_op == MIT_OP_SUB_IMM && !tbl_busy |=>
		flags.carry == ($past(cmd_imm) >= $past(acc)))
		else $error("carry flag wrong");
	a_tbl_two_cycle: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_tbl_start |-> s_tbl_load)
		else $error("table read not two cycles");
	a_tbl_addr_form: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_tbl_start |=> tbl_addr == {$past(table_pointer_high), $past(acc)})
		else $error("table address wrong");
	a_tbl_bus_stall: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		tbl_busy |=> avs_waitrequest_out)
		else $error("bus taken during table read");
	a_tbl_flags_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_tbl_start |-> ##2 $stable(flags) && flags == $past(flags, 2))
		else $error("table read changed flags");
	a_tbl_acc_load: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		tbl_busy |=> acc == rom[$past(tbl_addr)][7:0])
		else $error("table low byte wrong");
	a_tbl_high_load: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_tbl_start |-> ##2 table_data_high == rom[$past(tbl_addr)][13:8])
		else $error("table high bits wrong");
	a_spr_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		cmd_go && cmd_op == MIT_OP_SPR_WRITE && cmd_imm[3:0] != 4'hf |=>
		special_page_register[$past(cmd_imm[3:0])] == $past(acc) && $stable(flags))
		else $error("special page write wrong");
	a_spr_idx_drop: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		cmd_go && cmd_op == MIT_OP_SPR_WRITE && cmd_imm[3:0] == 4'hf |=>
		$stable(special_page_register[14]) && $stable(flags))
		else $error("special page index 15 not dropped");
	a_t0_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		cmd_go && cmd_op == MIT_OP_T0_WRITE |=> timer_zero_mode_reg == $past(acc)
		##1 timer_zero_mode_out == $past(acc, 2))
		else $error("timer mode write wrong");
	a_flags_sub_only: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		!$stable(flags) |-> $past(cmd_go && cmd_op == MIT_OP_SUB_IMM))
		else $error("flags changed outside subtract");
	// Waitrequest drops on the edge after an idle request
	a_bus_accept: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		s_bus_req |=> !avs_waitrequest_out)
		else $error("request not accepted");
	// Acceptance stands for one cycle only
	a_bus_one_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	// Accumulator read returns the value held when the read was taken
	a_rd_acc_data: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		req.read && !ack && !tbl_busy && req.address == `MIT_OFF_ACC |=>
		avs_readdata_out == {24'h000000, $past(acc)})
		else $error("accumulator read data wrong");
	// Loader address steps once per ROM data write
	a_rom_load_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		req.write && ack && req.address == `MIT_OFF_ROM_DATA |=>
		rom_load_addr == $past(rom_load_addr) + 11'h001)
		else $error("loader address did not step");
endmodule
`default_nettype wire

// File: dv/testbench.sv
`include "mit_regs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] avs_address_in = 8'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic [7:0] timer_zero_mode_out;
	logic [7:0] acc_out;
	int err_count = 0;
	int checks = 0;
	logic [31:0] q;
	// Subtract cases: accumulator, immediate, result, expected status
	logic [7:0] sub_tab [4][4] = '{'{8'h06, 8'h05, 8'hff, 8'h00}, '{8'h05, 8'h06, 8'h01, 8'h03},
		'{8'h0f, 8'h20, 8'h11, 8'h01}, '{8'h33, 8'h33, 8'h00, 8'h07}};
	mit_core DUT (
		.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .timer_zero_mode_out(timer_zero_mode_out),
		.acc_out(acc_out)
	);
	// Free-running system clock, 10 ns period
	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic close_out();
		$display("Counts: checks=%0d mismatches=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One bus access; request held until waitrequest is sampled low
	task automatic bus(input logic [7:0] a, input logic rd, input logic [31:0] d);
		int n;
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_read_in <= rd;
		avs_write_in <= ~rd;
		avs_writedata_in <= d;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 60);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (avs_waitrequest_out !== 1'b0) begin
			err_count++;
			$display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest_out);
			close_out();
		end
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b1, 32'h0);
		chk(name, exp, q);
	endtask
	// Load accumulator then issue one command word
	task automatic op(input logic [7:0] acc, input logic [31:0] cmd);
		bus(`MIT_OFF_ACC, 1'b0, {24'h0, acc});
		bus(`MIT_OFF_CMD, 1'b0, cmd);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		rd_chk("acc_reset", `MIT_OFF_ACC, 32'h0);
		rd_chk("status_reset", `MIT_OFF_STATUS, 32'h0);
		$display("Test reset done");
		// Borrow, no borrow, nibble-only borrow, zero result; zero case last
		for (int i = 0; i < 4; i++) begin
			op(sub_tab[i][0], {22'h0, 2'd0, sub_tab[i][1]});
			rd_chk("sub_acc", `MIT_OFF_ACC, {24'h0, sub_tab[i][2]});
			rd_chk("sub_status", `MIT_OFF_STATUS, {24'h0, sub_tab[i][3]});
		end
		$display("Test subtract done");
		bus(`MIT_OFF_ROM_ADDR, 1'b0, 32'h234);
		bus(`MIT_OFF_ROM_DATA, 1'b0, 32'h35aa);
		rd_chk("rom_addr_step", `MIT_OFF_ROM_ADDR, 32'h235);
		bus(`MIT_OFF_TBL_PTR_HI, 1'b0, 32'h0a);
		rd_chk("tbl_ptr_hi", `MIT_OFF_TBL_PTR_HI, 32'h02);
		op(8'h34, 32'h100);
		rd_chk("tbl_acc", `MIT_OFF_ACC, 32'haa);
		rd_chk("tbl_data_hi", `MIT_OFF_TBL_DATA_HI, 32'h35);
		rd_chk("tbl_status", `MIT_OFF_STATUS, 32'h07);
		chk("acc_port", 32'haa, {24'h0, acc_out});
		$display("Test table read done");
		op(8'haa, 32'h20e);
		op(8'h11, 32'h200);
		op(8'h77, 32'h20f);
		rd_chk("spr14", `MIT_OFF_SPR_BASE + 8'h38, 32'haa);
		rd_chk("spr0", `MIT_OFF_SPR_BASE, 32'h11);
		rd_chk("spr_status", `MIT_OFF_STATUS, 32'h07);
		$display("Test special page done");
		op(8'h5a, 32'h300);
		rd_chk("t0_reg", `MIT_OFF_T0_MODE, 32'h5a);
		rd_chk("t0_status", `MIT_OFF_STATUS, 32'h07);
		chk("t0_port", 32'h5a, {24'h0, timer_zero_mode_out});
		rd_chk("unmapped", 8'h30, 32'h0);
		$display("Test timer mode done");
		close_out();
	end
endmodule
`default_nettype wire
